// ### inc/ifx_regs.svh
// constants for the increment instruction execution block
`ifndef IFX_REGS_SVH
`define IFX_REGS_SVH
// ----------------------------------------
// instruction fields
// ----------------------------------------
`define IFX_OPC_INC 6'h0A
`define IFX_OPC_INCSZ 6'h0F
`define IFX_OPC_MSB 13
`define IFX_OPC_LSB 8
`define IFX_DEST_BIT 7
`define IFX_ADDR_MSB 6
`define IFX_DEST_WORK 1'h0
`define IFX_INCR 8'h01
`define IFX_W_RESET 8'h00
`endif

// ### inc/ifx_pkg.sv
// types for the increment instruction execution block
package ifx_pkg;
  // ----------------------------------------
  // phase state
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    IFX_Q1 = 2'b00,
    IFX_Q2 = 2'b01,
    IFX_Q3 = 2'b10,
    IFX_Q4 = 2'b11
  } ifx_phase_t;

  // file register write request
  typedef struct packed
  {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } ifx_fwrite_t;
endpackage

// ### logic/ifx_exec.sv
// execution logic for the increment-file instructions
`timescale 1ns/100ps
`include "ifx_regs.svh"
module ifx_exec
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [13:0] instr_in,
  input wire logic [7:0] file_rdata_in,
  output logic [6:0] file_raddr_out,
  output ifx_pkg::ifx_fwrite_t file_wr_out,
  output logic [7:0] work_out,
  output logic zero_out,
  output logic zero_we_out,
  output logic skip_out,
  output logic [1:0] phase_out,
  output logic busy_out
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [7:0] ifx_inc(input logic [7:0] v);
    ifx_inc = v + `IFX_INCR; // wraps modulo 256
  endfunction

  // opcode field match, shared by both decoders so they cannot drift apart
  function automatic logic ifx_opc_is(input logic [13:0] word, input logic [5:0] opc);
    ifx_opc_is = word[`IFX_OPC_MSB:`IFX_OPC_LSB] == opc;
  endfunction

  // zero test on an eight-bit result, used by the flag and by the skip
  function automatic logic ifx_is_zero(input logic [7:0] v);
    ifx_is_zero = v == 8'h00;
  endfunction

  ifx_pkg::ifx_phase_t phase_reg, phase_next;
  logic [13:0] ir_reg, ir_next;
  logic [7:0] res_reg, res_next;
  logic [7:0] w_reg, w_next;
  logic z_reg, z_next, zwe_reg, zwe_next;
  logic skp_reg, skp_next, nop_reg, nop_next;
  ifx_pkg::ifx_fwrite_t fw_reg, fw_next;
  logic is_inc, is_incsz;

  // opcode match on the latched word
  assign is_inc = ifx_opc_is(ir_reg, `IFX_OPC_INC);
  assign is_incsz = ifx_opc_is(ir_reg, `IFX_OPC_INCSZ);

  // ----------------------------------------
  // phase sequencing and datapath
  // ----------------------------------------
  // a skipped cycle still walks all four phases but changes nothing
  always_comb
  begin
    phase_next = phase_reg;
    ir_next = ir_reg;
    res_next = res_reg;
    w_next = w_reg;
    z_next = z_reg;
    zwe_next = 1'b0;
    skp_next = skp_reg;
    nop_next = nop_reg;
    fw_next = '0;
    case (phase_reg)
      ifx_pkg::IFX_Q1:
      begin
        ir_next = instr_in; // decode
        skp_next = 1'b0;
        phase_next = ifx_pkg::IFX_Q2;
      end
      ifx_pkg::IFX_Q2:
      begin
        res_next = file_rdata_in; // read file register
        phase_next = ifx_pkg::IFX_Q3;
      end
      ifx_pkg::IFX_Q3:
      begin
        res_next = ifx_inc(res_reg); // compute
        phase_next = ifx_pkg::IFX_Q4;
      end
      ifx_pkg::IFX_Q4:
      begin
        phase_next = ifx_pkg::IFX_Q1;
        nop_next = 1'b0;
        if (!nop_reg && (is_inc || is_incsz))
        begin
          // write destination
          if (ir_reg[`IFX_DEST_BIT] == `IFX_DEST_WORK)
            w_next = res_reg;
          else
          begin
            fw_next.en = 1'b1;
            fw_next.addr = ir_reg[`IFX_ADDR_MSB:0];
            fw_next.data = res_reg;
          end
          if (is_inc)
          begin
            z_next = ifx_is_zero(res_reg); // one cycle, zero flag
            zwe_next = 1'b1;
          end
          else if (ifx_is_zero(res_reg))
          begin
            nop_next = 1'b1; // next cycle becomes a no-op
            skp_next = 1'b1;
          end
        end
      end
      default:
        phase_next = ifx_pkg::IFX_Q1;
    endcase
  end

  // registers only
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase_reg <= ifx_pkg::IFX_Q1;
      ir_reg <= 14'h0000;
      res_reg <= 8'h00;
      w_reg <= `IFX_W_RESET;
      z_reg <= 1'b0;
      zwe_reg <= 1'b0;
      skp_reg <= 1'b0;
      nop_reg <= 1'b0;
      fw_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      ir_reg <= ir_next;
      res_reg <= res_next;
      w_reg <= w_next;
      z_reg <= z_next;
      zwe_reg <= zwe_next;
      skp_reg <= skp_next;
      nop_reg <= nop_next;
      fw_reg <= fw_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign file_raddr_out = ir_reg[`IFX_ADDR_MSB:0];
  assign file_wr_out = fw_reg;
  assign work_out = w_reg;
  assign zero_out = z_reg;
  assign zero_we_out = zwe_reg;
  assign skip_out = skp_reg; // tells fetch the next word is discarded
  assign phase_out = phase_reg;
  assign busy_out = nop_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  phase_order_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q4 |=> phase_reg == ifx_pkg::IFX_Q1)
    else $error("phase did not wrap to q1");
  phase_walk_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q1 |=> phase_reg == ifx_pkg::IFX_Q2 ##1
    phase_reg == ifx_pkg::IFX_Q3 ##1 phase_reg == ifx_pkg::IFX_Q4)
    else $error("phase order broken");
  inc_decode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q4 && !nop_reg && is_inc |=> zero_we_out)
    else $error("plain increment not executed");
  other_op_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q4 && !is_inc && !is_incsz |=> !file_wr_out.en && !zero_we_out)
    else $error("unrelated opcode acted");
  dest_file_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q4 && !nop_reg && (is_inc || is_incsz) && ir_reg[7]
    |=> file_wr_out.en && file_wr_out.data == $past(res_reg) && $stable(work_out))
    else $error("file destination not written");
  dest_work_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q4 && !nop_reg && (is_inc || is_incsz) && !ir_reg[7]
    |=> !file_wr_out.en && work_out == $past(res_reg))
    else $error("working destination not written");
  zero_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    zero_we_out |-> zero_out == (work_out == 8'h00 && !file_wr_out.en
    || file_wr_out.en && file_wr_out.data == 8'h00))
    else $error("zero flag mismatch");
  skip_nop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    skip_out && phase_reg == ifx_pkg::IFX_Q1 |=> busy_out [*3] ##1
    (!file_wr_out.en && !zero_we_out))
    else $error("skipped cycle not a no-op");
  wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q3 |=> res_reg == 8'($past(res_reg) + 8'h01))
    else $error("increment not modulo 256");

  // ----------------------------------------
  // checks on latches, strobes and the skip
  // ----------------------------------------
  // the word and the operand must be taken in their own phase, never later
  decode_latch_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q1 |=> ir_reg == $past(instr_in))
    else $error("instruction word not latched in q1");
  read_latch_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q2 |=> res_reg == $past(file_rdata_in))
    else $error("file data not latched in q2");
  // the fetch side relies on the skip only after a zero result of the skip variant
  skip_taken_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q4 && !nop_reg && is_incsz && ifx_is_zero(res_reg)
    |=> skip_out && busy_out)
    else $error("zero result did not skip");
  skip_nonzero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q4 && !(is_incsz && !nop_reg && ifx_is_zero(res_reg))
    |=> !skip_out && !busy_out)
    else $error("skip without zero result");
  nop_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    busy_out && phase_reg != ifx_pkg::IFX_Q4 |=> busy_out)
    else $error("no-op cycle cut short");
  // the skip variant leaves the zero flag alone
  skip_keeps_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg == ifx_pkg::IFX_Q4 && is_incsz |=> !zero_we_out && $stable(zero_out))
    else $error("skip variant touched the zero flag");
  zero_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    zero_we_out |=> !zero_we_out)
    else $error("zero flag strobe longer than one clock");
  // results may only move at the commit edge
  state_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase_reg != ifx_pkg::IFX_Q4 |=> $stable(work_out) && $stable(zero_out))
    else $error("result changed outside commit");
  fwrite_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    file_wr_out.en |=> !file_wr_out.en)
    else $error("file write strobe longer than one clock");
  fwrite_addr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    file_wr_out.en |-> file_wr_out.addr == file_raddr_out)
    else $error("file write to wrong address");
endmodule

// ### verification/ifx_exec_bench.sv
// self-checking bench for the increment-file execution block
`timescale 1ns/100ps
module ifx_exec_bench;
  logic clk_in, rst_n_in, zero_out, zero_we_out, skip_out, busy_out, skipping, wr, exp_zero;
  logic [13:0] instr_in;
  logic [7:0] file_rdata_in, work_out, exp_work, res;
  logic [6:0] file_raddr_out;
  logic [1:0] phase_out;
  ifx_pkg::ifx_fwrite_t file_wr_out;
  int errors, n_tests, seed, i;
  logic [31:0] r;
  ifx_exec DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
    .file_rdata_in(file_rdata_in), .file_raddr_out(file_raddr_out),
    .file_wr_out(file_wr_out), .work_out(work_out), .zero_out(zero_out),
    .zero_we_out(zero_we_out), .skip_out(skip_out), .phase_out(phase_out),
    .busy_out(busy_out));
  // ------------------------------
  // clock, 50 ns period
  // ------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // eight-bit increment, wraps so that FF gives 00
  function automatic logic [7:0] inc8(input logic [7:0] v);
    return v + 8'h01;
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("errors %0d, n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one instruction cycle, entered at the falling edge inside Q1
  task automatic run(input logic [5:0] opc, input logic d, input logic [6:0] a,
    input logic [7:0] rd);
    logic inc, isz;
    inc = (opc === 6'h0A) && !skipping;
    isz = (opc === 6'h0F) && !skipping;
    res = inc8(rd);
    instr_in = {opc, d, a};
    file_rdata_in = rd;
    check("phase", 16'(phase_out), 16'h0000);
    @(negedge clk_in);
    check("raddr", 16'(file_raddr_out), 16'(a));
    check("busy", 16'(busy_out), 16'(skipping));
    repeat (3) @(negedge clk_in);
    // results land at the edge leaving Q4, so they are seen in the next Q1
    wr = (inc || isz) && d;
    if (wr)
      check("fwrite", 16'(file_wr_out), {1'b1, a, res});
    else
      check("fwrite_en", 16'(file_wr_out.en), 16'h0000);
    if ((inc || isz) && !d)
      exp_work = res;
    check("work", 16'(work_out), 16'(exp_work));
    check("zero_we", 16'(zero_we_out), 16'(inc));
    if (inc)
      exp_zero = (res == 8'h00);
    check("zero", 16'(zero_out), 16'(exp_zero));
    skipping = isz && (res == 8'h00);
    check("skip", 16'(skip_out), 16'(skipping));
  endtask
  // ------------------------------
  // main sequence: corners, then random words
  // ------------------------------
  initial
  begin
    seed = 32'h8875;
    instr_in = 14'h0000;
    file_rdata_in = 8'h00;
    exp_work = 8'h00;
    exp_zero = 1'b0;
    skipping = 1'b0;
    rst_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check("work_rst", 16'(work_out), 16'h0000);
    rst_n_in = 1'b1;
    run(6'h0A, 1'b0, 7'h7F, 8'hFF);
    run(6'h0A, 1'b1, 7'h00, 8'h41);
    run(6'h0F, 1'b0, 7'h12, 8'hFF);
    run(6'h0A, 1'b1, 7'h33, 8'h10);
    run(6'h0F, 1'b1, 7'h05, 8'h05);
    run(6'h0F, 1'b1, 7'h7F, 8'hFF);
    // reset mid-run while a skip is pending: the no-op must be dropped
    rst_n_in = 1'b0;
    @(negedge clk_in);
    check("skip_rst", 16'({skip_out, busy_out, zero_out}), 16'h0000);
    check("work_rst", 16'(work_out), 16'h0000);
    exp_work = 8'h00;
    exp_zero = 1'b0;
    skipping = 1'b0;
    rst_n_in = 1'b1;
    run(6'h0F, 1'b0, 7'h01, 8'hFF);
    run(6'h3F, 1'b1, 7'h05, 8'h05);
    run(6'h2A, 1'b1, 7'h05, 8'h05);
    for (i = 0; i < 80; i++)
    begin
      r = $random(seed);
      run(r[1] ? (r[0] ? 6'h0F : 6'h0A) : r[13:8], r[3], r[22:16],
        r[2] ? 8'hFF : r[31:24]);
    end
    test_done();
  end
  // watchdog well beyond the 361 cycles the sequence needs
  initial
  begin
    #100000;
    errors++;
    test_done();
  end
endmodule
